// ===== design/brake_pkg.sv
/*
  Shared constants, register map and carrier types of the brake output sequencer.
  Assumes a 25 MHz ref_clk and a 32-bit Avalon-MM register bus with byte addresses.
*/
package brake_pkg;

  // ==========================================================
  // timing
  localparam int CLK_HZ      = 25_000_000;
  localparam int TICK_MS     = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // ==========================================================
  // register byte offsets
  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_CFG    = 6'h04;
  localparam logic [5:0] OFS_DLY    = 6'h08;
  localparam logic [5:0] OFS_WAIT   = 6'h0c;
  localparam logic [5:0] OFS_ROT    = 6'h10;
  localparam logic [5:0] OFS_LIN    = 6'h14;
  localparam logic [5:0] OFS_STATUS = 6'h18;
  localparam logic [5:0] OFS_IRQ_ST = 6'h1c;
  localparam logic [5:0] OFS_IRQ_MK = 6'h20;

  // ==========================================================
  // field positions
  localparam int CTRL_SRV_ON  = 0;  // two bits, one per axis
  localparam int CTRL_ZSTOP   = 2;
  localparam int CTRL_LINEAR  = 4;
  localparam int CTRL_RESTART = 8;
  localparam int CFG_BK_ALLOC = 0;  // two bits per axis
  localparam int CFG_TG_ALLOC = 4;
  localparam int CFG_RELAY    = 8;
  localparam int IRQ_BRAKE    = 0;
  localparam int IRQ_POWER    = 2;
  localparam int IRQ_ALARM    = 4;
  localparam int IRQ_W        = 6;

  // ==========================================================
  // ranges and reset values
  localparam logic [5:0]  DLY_MAX     = 6'h32;
  localparam logic [5:0]  DLY_RST     = 6'h00;
  localparam logic [5:0]  DLY_RST_BI  = 6'h20;
  localparam logic [6:0]  WAIT_MIN    = 7'h0a;
  localparam logic [6:0]  WAIT_MAX    = 7'h64;
  localparam logic [6:0]  WAIT_RST    = 7'h32;
  localparam logic [13:0] LVL_MAX     = 14'h2710;
  localparam logic [13:0] ROT_RST     = 14'h0064;
  localparam logic [13:0] LIN_RST     = 14'h000a;
  localparam logic [1:0]  ALLOC_NONE  = 2'h0;
  localparam logic [1:0]  ALLOC_PRI   = 2'h1;
  localparam logic [1:0]  ALLOC_ALT   = 2'h2;
  localparam logic [8:0]  CFG_RST     = 9'h055;
  localparam logic [5:0]  CTRL_RST    = 6'h00;

  // ==========================================================
  // types
  typedef enum logic [5:0] {
    ST_POWERED  = 6'h01,
    ST_OFF_DLY  = 6'h02,
    ST_ALM_STOP = 6'h04,
    ST_ALM_DLY  = 6'h08,
    ST_COAST    = 6'h10,
    ST_BRAKED   = 6'h20
  } axis_state_type;

  typedef struct packed {
    logic        servo_on;
    logic        zero_stop;
    logic [5:0]  delay;
    logic [6:0]  wait_t;
    logic [13:0] level;
  } axis_cfg_type;

  typedef struct packed {
    logic           brake_release;
    logic           power_on;
    logic           ev_brake;
    logic           ev_power;
    axis_state_type state;
  } axis_stat_type;

endpackage

// ===== design/brake_axis_seq.sv
/*
  One axis of the brake sequencer: servo-off delay, alarm stop and coast wait.
  Assumes settings already clamped and a one-cycle 10 ms tick from the parent.
*/
module brake_axis_seq
  import brake_pkg::*;
(
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        tick,
  // settings and live inputs
  input  wire axis_cfg_type cfg,
  input  wire logic        alarm,
  input  wire logic [15:0] speed,
  // state and events
  output axis_stat_type    stat
);

  axis_state_type state_ff;
  axis_state_type nxt_state;
  logic [6:0]     ticks_ff;
  logic           brake_ff;
  logic           power_ff;
  logic           ev_brake_ff;
  logic           ev_power_ff;
  logic           stopped;
  logic           slow;
  logic           nxt_rel;
  logic           nxt_pwr;

  assign stopped = (speed == 16'h0000);
  assign slow    = (speed < {2'h0, cfg.level});

  // ==========================================================
  // sequencing; overtravel is no input here, so it alone never brakes
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_POWERED: begin
        if (alarm && stopped)
          nxt_state = ST_BRAKED;
        else if (alarm && cfg.zero_stop)
          nxt_state = ST_ALM_STOP;
        else if (alarm)
          nxt_state = ST_COAST;
        else if (!cfg.servo_on && !stopped)
          nxt_state = ST_COAST;
        else if (!cfg.servo_on && cfg.delay == 6'h00)
          nxt_state = ST_BRAKED;
        else if (!cfg.servo_on)
          nxt_state = ST_OFF_DLY;
      end
      ST_OFF_DLY: begin
        if (alarm)
          nxt_state = ST_BRAKED;
        else if (ticks_ff >= {1'b0, cfg.delay})
          nxt_state = ST_BRAKED;
      end
      ST_ALM_STOP: begin
        if (stopped && cfg.delay == 6'h00)
          nxt_state = ST_BRAKED;
        else if (stopped)
          nxt_state = ST_ALM_DLY;
      end
      ST_ALM_DLY: begin
        if (ticks_ff >= {1'b0, cfg.delay})
          nxt_state = ST_BRAKED;
      end
      ST_COAST: begin
        if (slow)
          nxt_state = ST_BRAKED;
        else if (ticks_ff >= cfg.wait_t)
          nxt_state = ST_BRAKED;
      end
      ST_BRAKED: begin
        if (cfg.servo_on && !alarm)
          nxt_state = ST_POWERED;
      end
      default: nxt_state = ST_BRAKED;
    endcase
  end

  // release only while powered, stopping under power, or coasting
  assign nxt_rel = (nxt_state == ST_POWERED) || (nxt_state == ST_ALM_STOP) ||
                   (nxt_state == ST_COAST);
  assign nxt_pwr = (nxt_state == ST_POWERED) || (nxt_state == ST_OFF_DLY) ||
                   (nxt_state == ST_ALM_STOP) || (nxt_state == ST_ALM_DLY);

  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      state_ff <= ST_BRAKED;
    else if (clk_en)
      state_ff <= nxt_state;
  end

  // tick counter restarts on every state change, saturates at top
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      ticks_ff <= 7'h00;
    else if (clk_en) begin
      if (nxt_state != state_ff)
        ticks_ff <= 7'h00;
      else if (tick && ticks_ff != 7'h7f)
        ticks_ff <= ticks_ff + 7'h01;
    end
  end

  // outputs and one-cycle events
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      brake_ff    <= 1'b0;
      power_ff    <= 1'b0;
      ev_brake_ff <= 1'b0;
      ev_power_ff <= 1'b0;
    end else if (clk_en) begin
      brake_ff    <= nxt_rel;
      power_ff    <= nxt_pwr;
      ev_brake_ff <= brake_ff && !nxt_rel;
      ev_power_ff <= power_ff && !nxt_pwr;
    end
  end

  assign stat = '{brake_release: brake_ff, power_on: power_ff,
                  ev_brake: ev_brake_ff, ev_power: ev_power_ff, state: state_ff};

endmodule

// ===== design/brake_output_sequencer.sv
/*
  Brake output sequencer for two servo axes with Avalon-MM registers,
  output pin routing with OR merging, built-in relay drive and interrupt.
  Assumes motor speed magnitudes arrive on ref_clk; alarm and overtravel are pins.
*/
module brake_output_sequencer
  import brake_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES,
  parameter bit BUILTIN_BRAKE = 1'b0,
  parameter int MAX_SPEED     = 10000,
  parameter int ROTATION_DETECT_OUT_LEVEL    = 20
)
(
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // pins from the drive (asynchronous)
  input  wire logic [1:0]  alarm_in,
  input  wire logic [1:0]  overtravel_in,
  // speed magnitudes from the motor loop
  input  wire logic [15:0] motor_speed_a,
  input  wire logic [15:0] motor_speed_b,
  // outputs
  output logic      [3:0]  out_pin,
  output logic      [1:0]  motor_power_on,
  output logic             brake_relay_drive,
  output logic             irq
);

  // ==========================================================
  // elaboration checks
  generate
    if (TICK_CYCLES_P < 2 || MAX_SPEED < 1 || MAX_SPEED > 16383 ||
        ROTATION_DETECT_OUT_LEVEL < 0 || ROTATION_DETECT_OUT_LEVEL > 65535) begin : g_bad_param
      $error("brake_output_sequencer: parameter out of range");
    end
  endgenerate

  localparam int          TW      = $clog2(TICK_CYCLES_P);
  localparam logic [13:0] MAX_SPD = 14'(MAX_SPEED);
  localparam logic [15:0] ROTATION_DETECT_OUT_L  = 16'(ROTATION_DETECT_OUT_LEVEL);
  localparam logic [5:0]  DLY_A0  = BUILTIN_BRAKE ? DLY_RST_BI : DLY_RST;

  // ==========================================================
  // declarations
  logic [TW-1:0]   tick_cnt_ff;
  logic            tick_ff;
  logic [3:0]      sync1_ff;
  logic [3:0]      sync2_ff;
  logic [3:0]      sync3_ff;
  logic [3:0]      pin_filt_ff;
  logic [1:0]      alarm;
  logic [1:0]      overtravel;
  logic [1:0]      alarm_prev_ff;
  logic            wait_ff;
  logic [31:0]     rdata_ff;
  logic            req;
  logic            wr_go;
  logic [31:0]     rd_mux;
  logic [31:0]     wval;
  logic [5:0]      ctrl_ff;
  logic [8:0]      cfg_ff;
  logic [8:0]      act_cfg_ff;
  logic            restart_ff;
  logic [5:0]      dly_ff [2];
  logic [6:0]      wait_t_ff [2];
  logic [13:0]     rot_ff [2];
  logic [13:0]     lin_ff [2];
  logic [IRQ_W-1:0] irq_st_ff;
  logic [IRQ_W-1:0] irq_mk_ff;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] nxt_irq_st;
  logic            irq_ff;
  logic [3:0]      pin_ff;
  logic [3:0]      nxt_pin;
  logic [1:0]      pwr_ff;
  logic            relay_ff;
  logic [1:0]      rot_det;
  logic [1:0]      shared_warn;
  logic [15:0]     speed [2];
  axis_cfg_type    axis_cfg [2];
  axis_stat_type   axis_stat [2];

  // ==========================================================
  // helpers
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // out-of-range writes saturate rather than being refused
  function automatic logic [5:0] clamp_dly(input logic [7:0] v);
    return (v > {2'h0, DLY_MAX}) ? DLY_MAX : v[5:0];
  endfunction

  function automatic logic [6:0] clamp_wait(input logic [7:0] v);
    logic [6:0] r;
    r = v[6:0];
    if (v > {1'b0, WAIT_MAX})
      r = WAIT_MAX;
    else if (v < {1'b0, WAIT_MIN})
      r = WAIT_MIN;
    return r;
  endfunction

  function automatic logic [13:0] clamp_lvl(input logic [15:0] v);
    return (v > {2'h0, LVL_MAX}) ? LVL_MAX : v[13:0];
  endfunction

  // ==========================================================
  // 10 ms tick, shared by both axes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else if (clk_en) begin
      tick_ff <= (tick_cnt_ff == TW'(TICK_CYCLES_P - 1));
      if (tick_cnt_ff == TW'(TICK_CYCLES_P - 1))
        tick_cnt_ff <= '0;
      else
        tick_cnt_ff <= tick_cnt_ff + TW'(1);
    end
  end

  // ==========================================================
  // pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_ff    <= 4'h0;
      sync2_ff    <= 4'h0;
      sync3_ff    <= 4'h0;
      pin_filt_ff <= 4'h0;
    end else if (clk_en) begin
      sync1_ff    <= {overtravel_in, alarm_in};
      sync2_ff    <= sync1_ff;
      sync3_ff    <= sync2_ff;
      pin_filt_ff <= (sync2_ff & sync3_ff) | (pin_filt_ff & (sync2_ff | sync3_ff));
    end
  end

  assign alarm      = pin_filt_ff[1:0];
  assign overtravel = pin_filt_ff[3:2];

  // ==========================================================
  // avalon-mm: one wait cycle, then a single cycle with waitrequest low
  assign req   = avs_read || avs_write;
  assign wr_go = avs_write && !wait_ff;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      wait_ff <= !(req && wait_ff);
      if (avs_read && wait_ff)
        rdata_ff <= rd_mux;
    end
  end

  // read mux, also the base of byte-lane merges; unmapped reads zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      OFS_CTRL:   rd_mux = {26'h0, ctrl_ff};
      OFS_CFG:    rd_mux = {23'h0, cfg_ff};
      OFS_DLY:    rd_mux = {18'h0, dly_ff[1], 2'h0, dly_ff[0]};
      OFS_WAIT:   rd_mux = {17'h0, wait_t_ff[1], 1'b0, wait_t_ff[0]};
      OFS_ROT:    rd_mux = {2'h0, rot_ff[1], 2'h0, rot_ff[0]};
      OFS_LIN:    rd_mux = {2'h0, lin_ff[1], 2'h0, lin_ff[0]};
      OFS_STATUS: rd_mux = {2'h0, axis_stat[1].state, 2'h0, axis_stat[0].state,
                            1'b0, shared_warn, relay_ff, pin_ff,
                            overtravel, alarm, pwr_ff,
                            axis_stat[1].brake_release, axis_stat[0].brake_release};
      OFS_IRQ_ST: rd_mux = {26'h0, irq_st_ff};
      OFS_IRQ_MK: rd_mux = {26'h0, irq_mk_ff};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  assign wval = be_merge(rd_mux, avs_writedata, avs_byteenable);

  // ==========================================================
  // control: servo-on command, stop method, motor type, restart
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff    <= CTRL_RST;
      restart_ff <= 1'b1;
    end else if (clk_en) begin
      restart_ff <= 1'b0;
      if (wr_go && avs_address == OFS_CTRL) begin
        ctrl_ff    <= wval[5:0];
        restart_ff <= avs_byteenable[1] && avs_writedata[CTRL_RESTART];
      end
    end
  end

  // routing and relay settings only act after a restart
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_ff     <= CFG_RST;
      act_cfg_ff <= CFG_RST;
    end else if (clk_en) begin
      if (wr_go && avs_address == OFS_CFG)
        cfg_ff <= wval[8:0];
      if (restart_ff)
        act_cfg_ff <= cfg_ff;
    end
  end

  // timing and speed level settings act immediately
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dly_ff[0]    <= DLY_A0;
      dly_ff[1]    <= DLY_RST;
      wait_t_ff[0] <= WAIT_RST;
      wait_t_ff[1] <= WAIT_RST;
      rot_ff[0]    <= ROT_RST;
      rot_ff[1]    <= ROT_RST;
      lin_ff[0]    <= LIN_RST;
      lin_ff[1]    <= LIN_RST;
    end else if (clk_en && wr_go) begin
      case (avs_address)
        OFS_DLY: begin
          dly_ff[0] <= clamp_dly(wval[7:0]);
          dly_ff[1] <= clamp_dly(wval[15:8]);
        end
        OFS_WAIT: begin
          wait_t_ff[0] <= clamp_wait(wval[7:0]);
          wait_t_ff[1] <= clamp_wait(wval[15:8]);
        end
        OFS_ROT: begin
          rot_ff[0] <= clamp_lvl(wval[15:0]);
          rot_ff[1] <= clamp_lvl(wval[31:16]);
        end
        OFS_LIN: begin
          lin_ff[0] <= clamp_lvl(wval[15:0]);
          lin_ff[1] <= clamp_lvl(wval[31:16]);
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // axis sequencers
  assign speed[0] = motor_speed_a;
  assign speed[1] = motor_speed_b;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_axis
      logic [13:0] lvl_sel;
      assign lvl_sel = ctrl_ff[CTRL_LINEAR + g] ? lin_ff[g] : rot_ff[g];
      assign axis_cfg[g].servo_on  = ctrl_ff[CTRL_SRV_ON + g];
      assign axis_cfg[g].zero_stop = ctrl_ff[CTRL_ZSTOP + g];
      assign axis_cfg[g].delay     = dly_ff[g];
      assign axis_cfg[g].wait_t    = wait_t_ff[g];
      // a level above the motor maximum is treated as the maximum
      assign axis_cfg[g].level     = (lvl_sel > MAX_SPD) ? MAX_SPD : lvl_sel;
      assign rot_det[g]            = (speed[g] >= ROTATION_DETECT_OUT_L);

      brake_axis_seq u_seq (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .tick    (tick_ff),
        .cfg     (axis_cfg[g]),
        .alarm   (alarm[g]),
        .speed   (speed[g]),
        .stat    (axis_stat[g])
      );

      // flags a brake pin shared with rotation detect, which can block braking
      assign shared_warn[g] =
        (act_cfg_ff[CFG_BK_ALLOC + 2*g +: 2] inside {ALLOC_PRI, ALLOC_ALT}) &&
        (act_cfg_ff[CFG_BK_ALLOC + 2*g +: 2] == act_cfg_ff[CFG_TG_ALLOC + 2*g +: 2]);
    end
  endgenerate

  // ==========================================================
  // pin routing: functions on one pin are ORed together
  always_comb begin
    nxt_pin = 4'h0;
    for (int a = 0; a < 2; a++) begin
      if (act_cfg_ff[CFG_BK_ALLOC + 2*a +: 2] == ALLOC_PRI)
        nxt_pin[2*a] = nxt_pin[2*a] | axis_stat[a].brake_release;
      if (act_cfg_ff[CFG_BK_ALLOC + 2*a +: 2] == ALLOC_ALT)
        nxt_pin[2*a+1] = nxt_pin[2*a+1] | axis_stat[a].brake_release;
      if (act_cfg_ff[CFG_TG_ALLOC + 2*a +: 2] == ALLOC_PRI)
        nxt_pin[2*a] = nxt_pin[2*a] | rot_det[a];
      if (act_cfg_ff[CFG_TG_ALLOC + 2*a +: 2] == ALLOC_ALT)
        nxt_pin[2*a+1] = nxt_pin[2*a+1] | rot_det[a];
    end
  end

  // registered outputs; relay exists only on the built-in variant, axis A only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_ff   <= 4'h0;
      pwr_ff   <= 2'h0;
      relay_ff <= 1'b0;
    end else if (clk_en) begin
      pin_ff   <= nxt_pin;
      pwr_ff   <= {axis_stat[1].power_on, axis_stat[0].power_on};
      relay_ff <= BUILTIN_BRAKE && !act_cfg_ff[CFG_RELAY] &&
                  axis_stat[0].brake_release;
    end
  end

  // ==========================================================
  // interrupts: sticky status, write one to clear, set wins over clear
  assign irq_ev = {alarm & ~alarm_prev_ff,
                   axis_stat[1].ev_power, axis_stat[0].ev_power,
                   axis_stat[1].ev_brake, axis_stat[0].ev_brake};
  assign irq_clr = (wr_go && avs_address == OFS_IRQ_ST) ? wval[IRQ_W-1:0] : '0;
  assign nxt_irq_st = (irq_st_ff & ~irq_clr) | irq_ev;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alarm_prev_ff <= 2'h0;
      irq_st_ff     <= '0;
      irq_mk_ff     <= '0;
      irq_ff        <= 1'b0;
    end else if (clk_en) begin
      alarm_prev_ff <= alarm;
      irq_st_ff     <= nxt_irq_st;
      if (wr_go && avs_address == OFS_IRQ_MK)
        irq_mk_ff <= wval[IRQ_W-1:0];
      irq_ff <= |(nxt_irq_st & irq_mk_ff);
    end
  end

  // ==========================================================
  // port drivers
  assign avs_readdata      = rdata_ff;
  assign avs_waitrequest   = wait_ff;
  assign out_pin           = pin_ff;
  assign motor_power_on    = pwr_ff;
  assign brake_relay_drive = relay_ff;
  assign irq               = irq_ff;

endmodule

// ===== verification/brake_seq_asserts.sv
/* port checker of the brake sequencer, bound below
   assumes relay built in and in use whenever power rises, axis A never set to zero-speed stop */
module brake_seq_asserts (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  // register bus
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // axis A
  input wire logic [1:0]  alarm_in,
  input wire logic [15:0] motor_speed_a,
  input wire logic [1:0]  motor_power_on,
  input wire logic        brake_relay_drive
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // steps of the axis A sequence
  sequence alarm_still;
    alarm_in[0] && motor_speed_a == 16'h0;
  endsequence
  sequence coast_still;
    !motor_power_on[0] && motor_speed_a == 16'h0;
  endsequence
  a_bus_answer: assert property (clk_en && (avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("late answer");
  a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long answer");
  a_bus_idle: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("answer unasked");
  a_hole_zero: assert property (avs_read && avs_waitrequest && avs_address == 6'h3c
    |=> avs_readdata == 32'h0) else $error("hole read");
  // sync plus state plus output is at most seven edges
  a_alarm_cut: assert property (alarm_still [*8] |-> !motor_power_on[0])
    else $error("power kept");
  a_rest_braked: assert property (coast_still [*4] |-> !brake_relay_drive)
    else $error("brake not applied");
  a_power_release: assert property ($rose(motor_power_on[0]) |-> $rose(brake_relay_drive))
    else $error("power without release");
  a_release_power: assert property ($rose(brake_relay_drive) |-> motor_power_on[0])
    else $error("release without power");
endmodule
bind brake_output_sequencer brake_seq_asserts chk (.ref_clk, .rst, .clk_en, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .alarm_in, .motor_speed_a,
  .motor_power_on, .brake_relay_drive);

// ===== verification/motor_model.sv
/* motor on axis A: spins toward a target while powered, coasts down otherwise
   assumes the bench sets the target; axis B never turns */
module motor_model (
  // clock and drive
  input  wire logic        ref_clk,
  input  wire logic [1:0]  power_on,
  input  wire logic [15:0] target,
  // measured speeds
  output logic      [15:0] speed_a,
  output logic      [15:0] speed_b
);
  timeunit 1ns;
  timeprecision 1ns;
  assign speed_b = 16'h0;
  // friction loses one count a cycle, slow enough to watch the level
  initial speed_a = 16'h0;
  always @(posedge ref_clk) begin
    if (power_on[0] && speed_a < target) speed_a <= speed_a + 16'h4;
    else if (!power_on[0] && speed_a != 16'h0) speed_a <= speed_a - 16'h1;
  end
endmodule

// ===== verification/tb.sv
/* bench of the brake sequencer with a motor model on axis A
   assumes the design files and the port checker are compiled first */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import brake_pkg::*;
  logic        ref_clk, rst, avs_read, avs_write, avs_waitrequest, brake_relay_drive, irq;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [1:0]  alarm_in, overtravel_in, motor_power_on;
  logic [15:0] speed_a, speed_b, target;
  logic [3:0]  out_pin;
  int          miscompares, comparisons, n;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %0t got %h want %h", $time, g, e); end end
  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // short tick keeps timer runs brief; a low motor maximum makes the level clamp visible
  brake_output_sequencer #(.TICK_CYCLES_P(20), .BUILTIN_BRAKE(1'b1), .MAX_SPEED(950))
    DUT (.ref_clk, .rst,
    .clk_en(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
    .avs_readdata, .avs_waitrequest, .alarm_in, .overtravel_in, .motor_speed_a(speed_a),
    .motor_speed_b(speed_b), .out_pin, .motor_power_on, .brake_relay_drive, .irq);
  motor_model far (.ref_clk, .power_on(motor_power_on), .target, .speed_a, .speed_b);
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin miscompares++; stop_test(); end
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  // wait for relay (s=0) or axis A power (s=1) to reach v, counting cycles in n
  task automatic wait_on(input bit s, input logic v);
    n = 0;
    while ((s ? motor_power_on[0] : brake_relay_drive) !== v && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    if ((s ? motor_power_on[0] : brake_relay_drive) !== v) begin miscompares++; stop_test(); end
  endtask
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h0;
    avs_writedata = 32'h0;
    alarm_in = 2'h0;
    overtravel_in = 2'h0;
    target = 16'h0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFS_DLY, 32'h20);
    rd(OFS_WAIT, 32'h3232);
    rd(OFS_ROT, 32'h640064);
    rd(OFS_LIN, 32'ha000a);
    rd(OFS_CFG, 32'h55);
    rd(6'h3c, 32'h0);
    bus(1'b1, OFS_DLY, 32'h3f3f);
    rd(OFS_DLY, 32'h3232);
    bus(1'b1, OFS_WAIT, 32'h505);
    rd(OFS_WAIT, 32'ha0a);
    bus(1'b1, OFS_ROT, 32'h3fff3fff);
    rd(OFS_ROT, 32'h27102710);
    $display("settings test done");
    bus(1'b1, OFS_DLY, 32'h3);
    bus(1'b1, OFS_CTRL, 32'h1);
    wait_on(1'b1, 1'b1);
    bus(1'b1, OFS_CTRL, 32'h0);
    wait_on(1'b0, 1'b0);
    `CHK(n < 6, 1'b1)
    `CHK(motor_power_on[0], 1'b1)
    wait_on(1'b1, 1'b0);
    `CHK(n inside {[35:65]}, 1'b1)
    `CHK(irq, 1'b0)
    $display("servo off test done");
    // start from an empty status so the interrupt can only come from this alarm
    bus(1'b1, OFS_IRQ_ST, 32'h3f);
    bus(1'b1, OFS_IRQ_MK, 32'h4);
    bus(1'b1, OFS_CTRL, 32'h1);
    wait_on(1'b1, 1'b1);
    `CHK(irq, 1'b0)
    alarm_in <= 2'h1;
    wait_on(1'b1, 1'b0);
    `CHK(n < 9, 1'b1)
    `CHK(brake_relay_drive, 1'b0)
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b1)
    rd(OFS_IRQ_ST, 32'h15);
    bus(1'b1, OFS_IRQ_ST, 32'h3f);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    $display("alarm test done");
    // moving motor: brake waits for the speed level, overtravel alone never brakes
    target <= 16'd1000;
    alarm_in <= 2'h0;
    repeat (300) @(posedge ref_clk);
    bus(1'b1, OFS_ROT, 32'h3e8);
    overtravel_in <= 2'h3;
    repeat (10) @(posedge ref_clk);
    `CHK(brake_relay_drive, 1'b1)
    overtravel_in <= 2'h0;
    alarm_in <= 2'h1;
    wait_on(1'b1, 1'b0);
    `CHK(brake_relay_drive, 1'b1)
    wait_on(1'b0, 1'b0);
    `CHK(speed_a inside {[16'd940:16'd949]}, 1'b1)
    alarm_in <= 2'h0;
    repeat (300) @(posedge ref_clk);
    bus(1'b1, OFS_ROT, 32'h0);
    alarm_in <= 2'h1;
    wait_on(1'b1, 1'b0);
    wait_on(1'b0, 1'b0);
    `CHK(n inside {[175:205]}, 1'b1)
    `CHK(out_pin[0], 1'b1)
    $display("coast test done");
    // brake moved to its own alternate pin
    alarm_in <= 2'h0;
    wait_on(1'b1, 1'b1);
    bus(1'b1, OFS_CFG, 32'h146);
    bus(1'b1, OFS_CTRL, 32'h101);
    repeat (4) @(posedge ref_clk);
    `CHK(out_pin[1:0], 2'b10)
    `CHK(brake_relay_drive, 1'b0)
    $display("routing test done");
    stop_test();
  end
endmodule
